// file: fetch_model.sv
module fetch_model
(
  input  wire logic        clk,
  output logic             instr_valid,
  output logic [15:0]      instr_word
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    instr_valid = 1'b0;
    instr_word  = 16'hFFFF;
  end

  // one word per call; bus shows the inverse between words, never a stale word
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    instr_word  <= ~w;
  endtask
endmodule

// file: mcu_decode_pkg.sv
package mcu_decode_pkg;

  // ----------------------------------------
  // access bank and reset values
  // ----------------------------------------
  localparam logic [3:0]  ACC_BANK_LOW    = 4'h0;
  localparam logic [3:0]  ACC_BANK_HIGH   = 4'hF;
  localparam logic [7:0]  ACC_SPLIT_RESET = 8'h60;
  localparam logic [3:0]  BANK_RESET      = 4'h0;
  localparam logic [20:0] PTR_RESET       = 21'h000000;

  // ----------------------------------------
  // register offsets on the plain port
  // ----------------------------------------
  localparam logic [2:0] REG_BANK    = 3'h0;
  localparam logic [2:0] REG_STATUS  = 3'h1;
  localparam logic [2:0] REG_PROD_LO = 3'h2;
  localparam logic [2:0] REG_PROD_HI = 3'h3;
  localparam logic [2:0] REG_LATCH   = 3'h4;
  localparam logic [2:0] REG_PTR_LO  = 3'h5;
  localparam logic [2:0] REG_PTR_MID = 3'h6;
  localparam logic [2:0] REG_PTR_UP  = 3'h7;

  // ----------------------------------------
  // opcode patterns, most significant bits first
  // ----------------------------------------
  localparam logic [3:0]  OPC_SECOND = 4'hF;
  localparam logic [3:0]  OPC_COPY   = 4'hC;
  localparam logic [7:0]  OPC_GOTO   = 8'hEF;
  localparam logic [6:0]  OPC_CALL   = 7'h76;
  localparam logic [9:0]  OPC_PTR_LOAD = 10'h3B8;
  localparam logic [8:0]  OPC_INDEX    = 9'h1D7;
  localparam logic [4:0]  OPC_LONG_BR  = 5'h1A;
  localparam logic [4:0]  OPC_BCOND  = 5'h1C;
  localparam logic [4:0]  OPC_LIT8   = 5'h01;
  localparam logic [13:0] OPC_RETURN = 14'h0004;
  localparam logic [11:0] OPC_TABLE  = 12'h000;
  localparam logic [6:0]  OPC_MUL    = 7'h01;

  // ----------------------------------------
  // table pointer modes
  // ----------------------------------------
  localparam logic [1:0] TBL_KEEP     = 2'h0;
  localparam logic [1:0] TBL_POST_INC = 2'h1;
  localparam logic [1:0] TBL_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_PRE_INC  = 2'h3;

  typedef enum logic [1:0] {LIT_NONE, LIT_8, LIT_12, LIT_20} lit_width_type;
  typedef enum logic [2:0] {PEND_COPY, PEND_GOTO, PEND_CALL, PEND_PTR_LOAD, PEND_INDEX} pend_type;
  typedef enum logic {WORD_FIRST, WORD_SECOND} word_state_type;

endpackage

// file: mcu_opcode_field_decoder.sv
// The register addresses and the plain strobed port were chosen for this implementation.
module mcu_opcode_field_decoder
  import mcu_decode_pkg::*;
#(
  parameter logic [7:0] ACCESS_SPLIT = ACC_SPLIT_RESET
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                instr_valid,
  input  wire logic [15:0]         instr_word,
  input  wire logic [20:0]         pc_in,
  input  wire logic [7:0]          working_accumulator_in,
  input  wire logic [7:0]          file_data_in,
  input  wire logic [4:0]          alu_flags_in,
  input  wire logic                alu_flags_we,
  input  wire logic                table_read_valid,
  input  wire logic [7:0]          table_read_data,
  input  wire logic [2:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata_ff,
  output logic                     dec_valid_ff,
  output logic      [11:0]         file_addr_ff,
  output logic                     dest_to_file_ff,
  output logic                     dest_to_accum_ff,
  output logic      [2:0]          bit_sel_ff,
  output logic      [7:0]          bit_mask_ff,
  output logic      [1:0]          pointer_sel_ff,
  output logic                     pointer_load_ff,
  output logic      [11:0]         copy_src_ff,
  output logic      [11:0]         copy_dst_ff,
  output logic                     copy_go_ff,
  output logic      [19:0]         literal_ff,
  output lit_width_type            literal_width_ff,
  output logic                     shadow_xfer_ff,
  output logic      [19:0]         abs_target_ff,
  output logic                     abs_go_ff,
  output logic                     call_ff,
  output logic      [20:0]         branch_target_ff,
  output logic                     branch_go_ff,
  output logic      [6:0]          index_src_ff,
  output logic      [6:0]          index_dst_ff,
  output logic                     index_go_ff,
  output logic                     nop_ff,
  output logic                     second_word_error_ff,
  output logic                     table_go_ff,
  output logic                     table_write_ff,
  output logic      [20:0]         table_addr_ff,
  output logic      [7:0]          table_latch_ff,
  output logic      [20:0]         table_pointer_ff,
  output logic      [4:0]          status_ff,
  output logic      [7:0]          product_high_byte_ff,
  output logic      [7:0]          product_low_byte_ff,
  output logic      [3:0]          bank_select_register_ff
);

  // ----------------------------------------
  // opcode classes of the incoming word
  // ----------------------------------------
  word_state_type state_ff;
  pend_type       pend_ff;
  logic [11:0]    first_ff;
  logic           fast_ff;
  logic [20:0]    long_off;
  logic [20:0]    short_off;
  logic           first_take;
  logic           is_second;
  logic           is_table;
  logic           is_mul;
  logic [1:0]     tmode;

  assign first_take = instr_valid && (state_ff == WORD_FIRST);
  assign is_second  = instr_word[15:12] == OPC_SECOND;
  assign is_table   = (instr_word[15:4] == OPC_TABLE) && instr_word[3];
  assign is_mul     = instr_word[15:9] == OPC_MUL;
  assign tmode      = instr_word[1:0];

  // ----------------------------------------
  // branch offset widening
  // ----------------------------------------
  sign_extend #(.IN_W(11), .OUT_W(21)) u_long_off
  (
    .value_in  (instr_word[10:0]),
    .value_out (long_off)
  );

  sign_extend #(.IN_W(8), .OUT_W(21)) u_short_off
  (
    .value_in  (instr_word[7:0]),
    .value_out (short_off)
  );

  // ----------------------------------------
  // field decode and two-word sequencing
  // ----------------------------------------
  // pulses drop every cycle; fields hold until the next decoded word
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff             <= WORD_FIRST;
      pend_ff              <= PEND_COPY;
      first_ff             <= 12'h000;
      fast_ff              <= 1'b0;
      dec_valid_ff         <= 1'b0;
      file_addr_ff         <= 12'h000;
      dest_to_file_ff      <= 1'b0;
      dest_to_accum_ff     <= 1'b1;
      bit_sel_ff           <= 3'h0;
      bit_mask_ff          <= 8'h01;
      pointer_sel_ff       <= 2'h0;
      pointer_load_ff      <= 1'b0;
      copy_src_ff          <= 12'h000;
      copy_dst_ff          <= 12'h000;
      copy_go_ff           <= 1'b0;
      literal_ff           <= 20'h00000;
      literal_width_ff     <= LIT_NONE;
      shadow_xfer_ff       <= 1'b0;
      abs_target_ff        <= 20'h00000;
      abs_go_ff            <= 1'b0;
      call_ff              <= 1'b0;
      branch_target_ff     <= 21'h000000;
      branch_go_ff         <= 1'b0;
      index_src_ff         <= 7'h00;
      index_dst_ff         <= 7'h00;
      index_go_ff          <= 1'b0;
      nop_ff               <= 1'b0;
      second_word_error_ff <= 1'b0;
    end
    else
    begin
      dec_valid_ff         <= 1'b0;
      pointer_load_ff      <= 1'b0;
      copy_go_ff           <= 1'b0;
      abs_go_ff            <= 1'b0;
      branch_go_ff         <= 1'b0;
      index_go_ff          <= 1'b0;
      nop_ff               <= 1'b0;
      second_word_error_ff <= 1'b0;
      shadow_xfer_ff       <= 1'b0;
      if (instr_valid)
      begin
        dec_valid_ff <= 1'b1;
        case (state_ff)
          WORD_FIRST:
          begin
            if (instr_word[8])
              file_addr_ff <= {bank_select_register_ff, instr_word[7:0]};
            else if (instr_word[7:0] < ACCESS_SPLIT)
              file_addr_ff <= {ACC_BANK_LOW, instr_word[7:0]};
            else
              file_addr_ff <= {ACC_BANK_HIGH, instr_word[7:0]};
            dest_to_file_ff  <= instr_word[9];
            dest_to_accum_ff <= ~instr_word[9];
            bit_sel_ff       <= instr_word[11:9];
            bit_mask_ff      <= 8'h01 << instr_word[11:9];
            literal_ff       <= {12'h000, instr_word[7:0]};
            literal_width_ff <= LIT_NONE;
            first_ff         <= instr_word[11:0];
            if (is_second)
              nop_ff <= 1'b1;
            // copy waits for its destination word
            else if (instr_word[15:12] == OPC_COPY)
            begin
              pend_ff  <= PEND_COPY;
              state_ff <= WORD_SECOND;
            end
            else if (instr_word[15:8] == OPC_GOTO)
            begin
              pend_ff  <= PEND_GOTO;
              state_ff <= WORD_SECOND;
            end
            else if (instr_word[15:9] == OPC_CALL)
            begin
              pend_ff  <= PEND_CALL;
              fast_ff  <= instr_word[8];
              state_ff <= WORD_SECOND;
            end
            else if (instr_word[15:6] == OPC_PTR_LOAD)
            begin
              pend_ff  <= PEND_PTR_LOAD;
              state_ff <= WORD_SECOND;
            end
            else if (instr_word[15:7] == OPC_INDEX)
            begin
              pend_ff  <= PEND_INDEX;
              state_ff <= WORD_SECOND;
            end
            else if (instr_word[15:11] == OPC_LONG_BR)
            begin
              // wraps around the top of the 21-bit space on purpose
              branch_target_ff <= 21'(pc_in + long_off);
              branch_go_ff     <= 1'b1;
            end
            else if (instr_word[15:11] == OPC_BCOND)
            begin
              branch_target_ff <= 21'(pc_in + short_off);
              branch_go_ff     <= 1'b1;
            end
            else if (instr_word[15:11] == OPC_LIT8)
              literal_width_ff <= LIT_8;
            else if (instr_word[15:2] == OPC_RETURN)
              shadow_xfer_ff <= instr_word[0];
          end
          WORD_SECOND:
          begin
            state_ff <= WORD_FIRST;
            // a first word not followed by its partner is dropped
            if (!is_second)
              second_word_error_ff <= 1'b1;
            else
            begin
              case (pend_ff)
                PEND_COPY:
                begin
                  copy_src_ff <= first_ff;
                  copy_dst_ff <= instr_word[11:0];
                  copy_go_ff  <= 1'b1;
                end
                PEND_GOTO, PEND_CALL:
                begin
                  abs_target_ff    <= {instr_word[11:0], first_ff[7:0]};
                  literal_ff       <= {instr_word[11:0], first_ff[7:0]};
                  literal_width_ff <= LIT_20;
                  abs_go_ff        <= 1'b1;
                  call_ff          <= pend_ff == PEND_CALL;
                  // shadow transfer only in fast mode
                  shadow_xfer_ff   <= (pend_ff == PEND_CALL) && fast_ff;
                end
                PEND_PTR_LOAD:
                begin
                  pointer_sel_ff   <= first_ff[5:4];
                  literal_ff       <= {8'h00, first_ff[3:0], instr_word[7:0]};
                  literal_width_ff <= LIT_12;
                  pointer_load_ff  <= 1'b1;
                end
                default:
                begin
                  index_src_ff <= first_ff[6:0];
                  index_dst_ff <= instr_word[6:0];
                  index_go_ff  <= 1'b1;
                end
              endcase
            end
          end
          default: state_ff <= WORD_FIRST;
        endcase
      end
    end
  end

  // ----------------------------------------
  // table pointer and latch
  // ----------------------------------------
  // a table op in the same cycle outranks a software pointer write
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      table_pointer_ff <= PTR_RESET;
      table_addr_ff    <= PTR_RESET;
      table_go_ff      <= 1'b0;
      table_write_ff   <= 1'b0;
    end
    else
    begin
      table_go_ff <= 1'b0;
      if (first_take && is_table)
      begin
        table_go_ff    <= 1'b1;
        table_write_ff <= instr_word[2];
        if (tmode == TBL_PRE_INC)
          table_addr_ff <= 21'(table_pointer_ff + 21'h000001);
        else
          table_addr_ff <= table_pointer_ff;
        if (tmode == TBL_POST_INC || tmode == TBL_PRE_INC)
          table_pointer_ff <= 21'(table_pointer_ff + 21'h000001);
        else if (tmode == TBL_POST_DEC)
          table_pointer_ff <= 21'(table_pointer_ff - 21'h000001);
      end
      else if (reg_wr && reg_addr == REG_PTR_LO)
        table_pointer_ff[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == REG_PTR_MID)
        table_pointer_ff[15:8] <= reg_wdata;
      else if (reg_wr && reg_addr == REG_PTR_UP)
        table_pointer_ff[20:16] <= reg_wdata[4:0];
    end
  end

  // read data beats a software write
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      table_latch_ff <= 8'h00;
    else if (table_read_valid)
      table_latch_ff <= table_read_data;
    else if (reg_wr && reg_addr == REG_LATCH)
      table_latch_ff <= reg_wdata;
  end

  // ----------------------------------------
  // flags, product and bank select
  // ----------------------------------------
  // five flags from the datapath
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      status_ff <= 5'h00;
    else if (alu_flags_we)
      status_ff <= alu_flags_in;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      product_high_byte_ff <= 8'h00;
      product_low_byte_ff  <= 8'h00;
    end
    else if (first_take && is_mul)
      {product_high_byte_ff, product_low_byte_ff} <= working_accumulator_in * file_data_in;
  end

  // bank select is software owned only
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bank_select_register_ff <= BANK_RESET;
    else if (reg_wr && reg_addr == REG_BANK)
      bank_select_register_ff <= reg_wdata[3:0];
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  // data stands in the cycle after each read strobe cycle, zero otherwise
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rdata_ff <= 8'h00;
    else if (!reg_rd)
      reg_rdata_ff <= 8'h00;
    else if (reg_addr == REG_BANK)
      reg_rdata_ff <= {4'h0, bank_select_register_ff};
    else if (reg_addr == REG_STATUS)
      reg_rdata_ff <= {3'h0, status_ff};
    else if (reg_addr == REG_PROD_LO)
      reg_rdata_ff <= product_low_byte_ff;
    else if (reg_addr == REG_PROD_HI)
      reg_rdata_ff <= product_high_byte_ff;
    else if (reg_addr == REG_LATCH)
      reg_rdata_ff <= table_latch_ff;
    else if (reg_addr == REG_PTR_LO)
      reg_rdata_ff <= table_pointer_ff[7:0];
    else if (reg_addr == REG_PTR_MID)
      reg_rdata_ff <= table_pointer_ff[15:8];
    else
      reg_rdata_ff <= {3'h0, table_pointer_ff[20:16]};
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence copy_start;
    first_take && instr_word[15:12] == OPC_COPY;
  endsequence
  // the partner word may follow after idle cycles; state ties it to its first word
  sequence pair_finish;
    instr_valid && is_second && state_ff == WORD_SECOND;
  endsequence

  access_bank_a: assert property (first_take && !instr_word[8] |=>
    file_addr_ff[11:8] == ($past(instr_word[7:0]) < ACCESS_SPLIT ? ACC_BANK_LOW : ACC_BANK_HIGH))
    else $error("access bank address wrong");
  dest_select_a: assert property (first_take |=>
    dest_to_file_ff == $past(instr_word[9]) && dest_to_accum_ff != dest_to_file_ff)
    else $error("destination select wrong");
  bit_mask_a: assert property (first_take |=>
    bit_sel_ff == $past(instr_word[11:9]) && $onehot(bit_mask_ff) && bit_mask_ff[bit_sel_ff])
    else $error("bit mask does not match bit number");
  copy_pair_a: assert property (copy_start ##[1:2] pair_finish |=>
    copy_go_ff && copy_src_ff == $past(first_ff) && copy_dst_ff == $past(instr_word[11:0]))
    else $error("register copy addresses wrong");
  abs_target_a: assert property (first_take && instr_word[15:8] == OPC_GOTO
    ##[1:2] pair_finish |=> abs_go_ff && abs_target_ff[7:0] == $past(first_ff[7:0], 1)
    && abs_target_ff[19:8] == $past(instr_word[11:0]) && literal_width_ff == LIT_20)
    else $error("absolute target wrong");
  long_branch_a: assert property (first_take && instr_word[15:11] == OPC_LONG_BR |=>
    branch_go_ff && branch_target_ff
    == $past(pc_in) + {{10{$past(instr_word[10])}}, $past(instr_word[10:0])})
    else $error("long branch target wrong");
  orphan_nop_a: assert property (first_take && is_second |=>
    nop_ff && !copy_go_ff && !abs_go_ff && state_ff == WORD_FIRST)
    else $error("lone second word not a no-operation");
  table_mode_a: assert property (first_take && is_table && tmode == TBL_POST_DEC |=>
    table_pointer_ff == $past(table_pointer_ff) - 21'h000001
    && table_addr_ff == $past(table_pointer_ff))
    else $error("table post-decrement wrong");
  product_split_a: assert property (first_take && is_mul |=>
    {product_high_byte_ff, product_low_byte_ff}
    == $past(working_accumulator_in) * $past(file_data_in))
    else $error("product bytes wrong");
  fast_return_a: assert property (first_take && instr_word[15:2] == OPC_RETURN |=>
    shadow_xfer_ff == $past(instr_word[0]) ##1 !shadow_xfer_ff || $past(instr_valid))
    else $error("return shadow transfer wrong");

endmodule

// file: mcu_opcode_field_decoder_bench.sv
module mcu_opcode_field_decoder_bench import mcu_decode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, instr_valid, reg_wr = 1'b0, reg_rd = 1'b0;
  logic alu_flags_we = 1'b0, table_read_valid = 1'b0;
  logic [15:0] instr_word;
  logic [20:0] pc_in = 21'h000100;
  logic [7:0] working_accumulator_in = 8'h12, file_data_in = 8'h34, reg_wdata = 8'h00;
  logic [7:0] table_read_data = 8'h00, reg_rdata_ff, bit_mask_ff, table_latch_ff;
  logic [7:0] product_high_byte_ff, product_low_byte_ff;
  logic [4:0] alu_flags_in = 5'h00, status_ff;
  logic [2:0] reg_addr = 3'h0, bit_sel_ff;
  logic dec_valid_ff, dest_to_file_ff, dest_to_accum_ff, pointer_load_ff, copy_go_ff;
  logic shadow_xfer_ff, abs_go_ff, call_ff, branch_go_ff, index_go_ff, nop_ff;
  logic second_word_error_ff, table_go_ff, table_write_ff;
  logic [11:0] file_addr_ff, copy_src_ff, copy_dst_ff;
  logic [1:0] pointer_sel_ff;
  logic [19:0] literal_ff, abs_target_ff;
  lit_width_type literal_width_ff;
  logic [20:0] branch_target_ff, table_addr_ff, table_pointer_ff;
  logic [6:0] index_src_ff, index_dst_ff;
  logic [3:0] bank_select_register_ff;
  int fail_count = 0;
  int checks_done = 0;

  always #4 clk = ~clk;

  fetch_model i_fetch_model (.clk, .instr_valid, .instr_word);

  mcu_opcode_field_decoder i_mcu_opcode_field_decoder (.clk, .reset, .instr_valid,
    .instr_word, .pc_in, .working_accumulator_in, .file_data_in, .alu_flags_in,
    .alu_flags_we, .table_read_valid, .table_read_data, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_ff, .dec_valid_ff, .file_addr_ff, .dest_to_file_ff,
    .dest_to_accum_ff, .bit_sel_ff, .bit_mask_ff, .pointer_sel_ff, .pointer_load_ff,
    .copy_src_ff, .copy_dst_ff, .copy_go_ff, .literal_ff, .literal_width_ff,
    .shadow_xfer_ff, .abs_target_ff, .abs_go_ff, .call_ff, .branch_target_ff,
    .branch_go_ff, .index_src_ff, .index_dst_ff, .index_go_ff, .nop_ff,
    .second_word_error_ff, .table_go_ff, .table_write_ff, .table_addr_ff,
    .table_latch_ff, .table_pointer_ff, .status_ff, .product_high_byte_ff,
    .product_low_byte_ff, .bank_select_register_ff);

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  // wide enough for the longest packed group compared at once
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // word is taken at the second edge; pulses are looked at just after it
  task automatic op(input logic [15:0] w);
    i_fetch_model.send(w);
    #1;
  endtask

  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_ff, exp);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_byte_fields();
    reg_write(REG_BANK, 8'h03);
    reg_read(REG_BANK, 8'h03);
    chk(bank_select_register_ff, 4'h3);
    op(16'h27AB);
    chk(file_addr_ff, 21'h0003AB);
    chk(dest_to_file_ff, 1'b1);
    op(16'h2450);
    chk(file_addr_ff, 21'h000050);
    chk(dest_to_accum_ff, 1'b1);
    op(16'h2480);
    chk(file_addr_ff, 21'h000F80);
    op(16'h8A10);
    chk({dec_valid_ff, bit_sel_ff, bit_mask_ff}, {1'b1, 3'h5, 8'h20});
  endtask

  task automatic test_two_word();
    op(16'hC123);
    op(16'hF456);
    chk({copy_go_ff, copy_src_ff, copy_dst_ff}, {1'b1, 12'h123, 12'h456});
    // a partner word without the 1111 top must not complete the copy
    op(16'hC123);
    op(16'h0E11);
    chk({second_word_error_ff, copy_go_ff, nop_ff}, 3'b100);
    op(16'hEF34);
    op(16'hF123);
    chk({abs_go_ff, call_ff, abs_target_ff}, {2'b10, 20'h12334});
    op(16'hED56);
    op(16'hFABC);
    chk({call_ff, shadow_xfer_ff, abs_target_ff}, {2'b11, 20'hABC56});
    op(16'h0012);
    chk(shadow_xfer_ff, 1'b0);
    op(16'h0013);
    chk(shadow_xfer_ff, 1'b1);
    op(16'hEE25);
    op(16'hF0AB);
    chk({pointer_load_ff, pointer_sel_ff, literal_ff}, {3'b110, 20'h005AB});
    chk(literal_width_ff, LIT_12);
    op(16'hEB95);
    op(16'hF02A);
    chk({index_go_ff, index_src_ff, index_dst_ff}, {1'b1, 7'h15, 7'h2A});
    op(16'hF123);
    chk(nop_ff, 1'b1);
    op(16'h0E7F);
    chk({literal_width_ff, literal_ff}, {LIT_8, 20'h0007F});
  endtask

  task automatic test_branch();
    op(16'hD7FF);
    chk({branch_go_ff, branch_target_ff}, {1'b1, 21'h0000FF});
    op(16'hD400);
    chk(branch_target_ff, 21'h1FFD00);
    op(16'hE0FE);
    chk(branch_target_ff, 21'h0000FE);
  endtask

  task automatic test_table();
    reg_write(REG_PTR_LO, 8'h10);
    op(16'h0009);
    chk({table_go_ff, table_write_ff, table_addr_ff, table_pointer_ff},
        {2'b10, 21'h10, 21'h11});
    op(16'h000B);
    chk({table_addr_ff, table_pointer_ff}, {21'h12, 21'h12});
    op(16'h000A);
    chk({table_addr_ff, table_pointer_ff}, {21'h12, 21'h11});
    op(16'h0008);
    chk({table_addr_ff, table_pointer_ff}, {21'h11, 21'h11});
    op(16'h000D);
    chk({table_go_ff, table_write_ff, table_addr_ff, table_pointer_ff},
        {2'b11, 21'h11, 21'h12});
    @(posedge clk);
    table_read_valid <= 1'b1;
    table_read_data  <= 8'hA5;
    @(posedge clk);
    table_read_valid <= 1'b0;
    reg_read(REG_LATCH, 8'hA5);
    chk(table_latch_ff, 8'hA5);
  endtask

  task automatic test_alu();
    op(16'h0200);
    chk({product_high_byte_ff, product_low_byte_ff}, 16'h03A8);
    reg_read(REG_PROD_HI, 8'h03);
    reg_read(REG_PROD_LO, 8'hA8);
    @(posedge clk);
    alu_flags_we <= 1'b1;
    alu_flags_in <= 5'h15;
    @(posedge clk);
    alu_flags_we <= 1'b0;
    reg_write(REG_STATUS, 8'h1F);
    reg_read(REG_STATUS, 8'h15);
    chk(status_ff, 5'h15);
  endtask

  task automatic conclude();
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    #50000;
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    test_byte_fields();
    test_two_word();
    test_branch();
    test_table();
    test_alu();
    conclude();
  end
endmodule

// file: sign_extend.sv
// ----------------------------------------
// two's complement widening
// ----------------------------------------
module sign_extend #(
  parameter int IN_W  = 8,
  parameter int OUT_W = 21
) (
  input  wire logic [IN_W-1:0]  value_in,
  output wire logic [OUT_W-1:0] value_out
);

  // widening only; narrowing would silently drop the sign
  if (IN_W < 2 || IN_W >= OUT_W)
  begin : g_bad_width
    $error("sign_extend needs 2 <= IN_W < OUT_W");
  end

  // copy the sign bit into every upper position
  assign value_out = {{(OUT_W-IN_W){value_in[IN_W-1]}}, value_in};

endmodule
